// ==== rtl/t1_alarm_irq_status.sv ====
// T1 receive defect tracking with group-gated interrupt output and AXI4-Lite registers.
// Assumes line inputs synchronous to aclk, one line_bit_en pulse per received bit.
`timescale 1ns/10ps

module t1_alarm_irq_status #(
  parameter int AIS_PERSIST_BITS    = t1_alarm_pkg::AIS_PERSIST_BITS,
  parameter int YELLOW_PERSIST_BITS = t1_alarm_pkg::YELLOW_PERSIST_BITS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        line_bit_en,
  input  wire logic        line_bit,
  input  wire logic        framing_bit_check,
  input  wire logic        framing_bit_error,
  input  wire logic        ais_cond,
  input  wire logic        rai_cond,
  input  wire logic        los_cond,
  input  wire logic        lcv_event,
  input  wire logic        slip_irq_pending,
  input  wire logic        framer_irq_pending,
  output logic             irq
);

  localparam int AIS_W = $clog2(AIS_PERSIST_BITS + 1);
  localparam int YEL_W = $clog2(YELLOW_PERSIST_BITS + 1);
  localparam int LOS_W = $clog2(t1_alarm_pkg::LOS_PERSIST_BITS + 1);

  if (AIS_PERSIST_BITS < 2 || YELLOW_PERSIST_BITS < 2) begin : bad_param
    $error("persistence counts must be at least 2");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [2:0]                           block_irq_enable;
  logic [3:0]                           src_irq_enable;
  logic [t1_alarm_pkg::TOLERANCE_W-1:0] frame_error_tolerance;
  logic [t1_alarm_pkg::WINDOW_W-1:0]    frame_error_window;
  logic [t1_alarm_pkg::CHG_FLAGS_W-1:0] chg_flags;
  logic                                 frame_loss_flag;
  logic                                 ais_defect_flag;
  logic                                 yellow_alarm_flag;
  logic                                 signal_loss_flag;
  logic [2:0]                           defect_prev;
  logic                                 slip_group_irq_en;
  logic                                 alarm_group_irq_en;
  logic                                 framer_group_irq_en;
  logic [7:0]                           alarm_error_irq_status;

  assign slip_group_irq_en   = block_irq_enable[t1_alarm_pkg::SLIP_GROUP_BIT];
  assign alarm_group_irq_en  = block_irq_enable[t1_alarm_pkg::ALARM_GROUP_BIT];
  assign framer_group_irq_en = block_irq_enable[t1_alarm_pkg::FRAMER_GROUP_BIT];
  assign alarm_error_irq_status = {frame_loss_flag, ais_defect_flag, yellow_alarm_flag,
                                   signal_loss_flag, chg_flags};

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr[7:2] == offset[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = reg_hit(addr, t1_alarm_pkg::OFF_BLOCK_IRQ_ENABLE)
           | reg_hit(addr, t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_STATUS)
           | reg_hit(addr, t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_ENABLE)
           | reg_hit(addr, t1_alarm_pkg::OFF_FRAME_LOSS_CFG);
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        do_write;

  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
  assign do_write      = ce && aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= t1_alarm_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_addr) ? t1_alarm_pkg::RESP_OKAY : t1_alarm_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Only the low byte lane carries register bits, except the frame loss window in byte lane 1
  logic byte0_write;
  assign byte0_write = do_write && wr_strb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      block_irq_enable <= t1_alarm_pkg::BLOCK_EN_RESET;
    else if (ce && byte0_write && reg_hit(wr_addr, t1_alarm_pkg::OFF_BLOCK_IRQ_ENABLE))
      block_irq_enable <= wr_data[2:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_irq_enable <= t1_alarm_pkg::SRC_EN_RESET;
    else if (ce && byte0_write && reg_hit(wr_addr, t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_ENABLE))
      src_irq_enable <= wr_data[3:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frame_error_tolerance <= t1_alarm_pkg::TOLERANCE_RESET;
      frame_error_window    <= t1_alarm_pkg::WINDOW_RESET;
    end
    else if (ce && do_write && reg_hit(wr_addr, t1_alarm_pkg::OFF_FRAME_LOSS_CFG))
    begin
      if (wr_strb[0])
        frame_error_tolerance <= wr_data[t1_alarm_pkg::TOLERANCE_LSB +: t1_alarm_pkg::TOLERANCE_W];
      if (wr_strb[1])
        frame_error_window <= wr_data[t1_alarm_pkg::WINDOW_LSB +: t1_alarm_pkg::WINDOW_W];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic ar_fire;
  logic status_read;

  assign s_axi_arready = ce && !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign status_read   = ar_fire && reg_hit(s_axi_araddr, t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= t1_alarm_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= t1_alarm_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (reg_hit(s_axi_araddr, t1_alarm_pkg::OFF_BLOCK_IRQ_ENABLE))
          s_axi_rdata[2:0] <= block_irq_enable;
        else if (reg_hit(s_axi_araddr, t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_STATUS))
          s_axi_rdata[7:0] <= alarm_error_irq_status;
        else if (reg_hit(s_axi_araddr, t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_ENABLE))
          s_axi_rdata[3:0] <= src_irq_enable;
        else if (reg_hit(s_axi_araddr, t1_alarm_pkg::OFF_FRAME_LOSS_CFG))
        begin
          s_axi_rdata[t1_alarm_pkg::TOLERANCE_LSB +: t1_alarm_pkg::TOLERANCE_W] <=
            frame_error_tolerance;
          s_axi_rdata[t1_alarm_pkg::WINDOW_LSB +: t1_alarm_pkg::WINDOW_W] <= frame_error_window;
        end
        else
          s_axi_rresp <= t1_alarm_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Loss of frame monitor
  // ----------------------------------------------------------------
  logic [t1_alarm_pkg::WINDOW_W-1:0]    lof_win_cnt;
  logic [t1_alarm_pkg::TOLERANCE_W-1:0] lof_err_cnt;
  logic                                 lof_win_end;
  logic [t1_alarm_pkg::TOLERANCE_W-1:0] lof_err_next;

  assign lof_win_end  = framing_bit_check && (lof_win_cnt + 8'h01 >= frame_error_window);
  assign lof_err_next = lof_err_cnt + {3'h0, framing_bit_error};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lof_win_cnt     <= '0;
      lof_err_cnt     <= '0;
      frame_loss_flag <= 1'b0;
    end
    else if (ce && framing_bit_check)
    begin
      lof_win_cnt <= lof_win_end ? '0 : lof_win_cnt + 8'h01;
      lof_err_cnt <= lof_win_end ? '0 : lof_err_next;
      if (framing_bit_error && lof_err_next >= frame_error_tolerance)
        frame_loss_flag <= 1'b1;
      // A clean window ends the loss of frame
      else if (lof_win_end && lof_err_next == '0)
        frame_loss_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AIS and yellow persistence timers
  // ----------------------------------------------------------------
  logic [AIS_W-1:0] ais_cnt;
  logic [YEL_W-1:0] yel_cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ais_cnt         <= '0;
      ais_defect_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (ais_cond == ais_defect_flag)
        ais_cnt <= '0;
      else if (line_bit_en)
      begin
        if (ais_cnt == AIS_W'(AIS_PERSIST_BITS - 1))
        begin
          ais_cnt         <= '0;
          ais_defect_flag <= ais_cond;
        end
        else
          ais_cnt <= ais_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      yel_cnt           <= '0;
      yellow_alarm_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (!rai_cond)
      begin
        yel_cnt           <= '0;
        yellow_alarm_flag <= 1'b0;
      end
      else if (!yellow_alarm_flag && line_bit_en)
      begin
        if (yel_cnt == YEL_W'(YELLOW_PERSIST_BITS - 1))
          yellow_alarm_flag <= 1'b1;
        else
          yel_cnt <= yel_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loss of signal
  // ----------------------------------------------------------------
  logic [LOS_W-1:0] los_run;
  logic [LOS_W-1:0] dens_cnt;
  logic [LOS_W-1:0] ones_cnt;
  logic [LOS_W-1:0] ones_next;
  logic             dens_end;

  assign ones_next = ones_cnt + {{(LOS_W-1){1'b0}}, line_bit};
  assign dens_end  = dens_cnt == LOS_W'(t1_alarm_pkg::LOS_PERSIST_BITS - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      los_run          <= '0;
      dens_cnt         <= '0;
      ones_cnt         <= '0;
      signal_loss_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (!los_cond)
      begin
        los_run          <= '0;
        dens_cnt         <= '0;
        ones_cnt         <= '0;
        signal_loss_flag <= 1'b0;
      end
      else if (line_bit_en && !signal_loss_flag)
      begin
        if (los_run == LOS_W'(t1_alarm_pkg::LOS_PERSIST_BITS - 1))
          signal_loss_flag <= 1'b1;
        else
          los_run <= los_run + 1'b1;
      end
      // Window aligned to LOS start, so earlier ones cannot cut the run
      if (line_bit_en && los_cond)
      begin
        dens_cnt <= dens_end ? '0 : dens_cnt + 1'b1;
        ones_cnt <= dens_end ? '0 : ones_next;
        if (dens_end && ones_next >= LOS_W'(t1_alarm_pkg::LOS_ONES_MIN))
        begin
          signal_loss_flag <= 1'b0;
          los_run          <= '0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Change flags and interrupt output
  // ----------------------------------------------------------------
  logic [3:0] chg_set;
  logic [3:0] chg_clr;

  assign chg_set = {lcv_event,
                    defect_prev ^ {frame_loss_flag, ais_defect_flag, yellow_alarm_flag}};
  assign chg_clr = status_read ? 4'hF :
                   (byte0_write && reg_hit(wr_addr, t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_STATUS))
                   ? wr_data[3:0] : 4'h0;

  // both edges set, read clears, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      defect_prev <= 3'h0;
      chg_flags   <= '0;
    end
    else if (ce)
    begin
      defect_prev <= {frame_loss_flag, ais_defect_flag, yellow_alarm_flag};
      chg_flags   <= (chg_flags & ~chg_clr) | chg_set;
    end
  end

  logic alarm_pending;
  assign alarm_pending = |(chg_flags & src_irq_enable);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else if (ce)
      irq <= (slip_group_irq_en && slip_irq_pending)
           | (alarm_group_irq_en && alarm_pending)
           | (framer_group_irq_en && framer_irq_pending);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  slip_gate_a: assert property (ce && !slip_group_irq_en && !(alarm_group_irq_en && alarm_pending)
    && !(framer_group_irq_en && framer_irq_pending) |=> !irq)
    else $error("slip interrupt passed a closed group");
  alarm_gate_a: assert property (ce && !alarm_group_irq_en && !slip_irq_pending
    && !framer_irq_pending |=> !irq)
    else $error("alarm interrupt passed a closed group");
  framer_gate_a: assert property (ce && framer_group_irq_en && framer_irq_pending |=> irq)
    else $error("enabled framer interrupt did not reach irq");
  source_gate_a: assert property (ce && alarm_group_irq_en && src_irq_enable == 4'h0
    && !slip_irq_pending && !framer_irq_pending |=> !irq)
    else $error("group enable alone raised irq");
  group_reset_a: assert property (disable iff (1'b0) !aresetn |=> block_irq_enable == 3'h0)
    else $error("group enables not cleared by reset");
  lof_declare_a: assert property ($rose(frame_loss_flag) |-> $past(framing_bit_error))
    else $error("frame loss declared without a framing error");
  ais_timer_a: assert property ($changed(ais_defect_flag)
    |-> $past(ais_cnt) == AIS_W'(AIS_PERSIST_BITS - 1))
    else $error("AIS changed before its persistence time");
  yel_timer_a: assert property ($rose(yellow_alarm_flag)
    |-> $past(yel_cnt) == YEL_W'(YELLOW_PERSIST_BITS - 1))
    else $error("yellow declared before its persistence time");
  yel_clear_a: assert property (ce && !rai_cond |=> !yellow_alarm_flag)
    else $error("yellow alarm not cleared at once");
  los_timer_a: assert property ($rose(signal_loss_flag)
    |-> $past(los_run) == LOS_W'(t1_alarm_pkg::LOS_PERSIST_BITS - 1))
    else $error("loss of signal declared early");
  los_clear_a: assert property (ce && !los_cond |=> !signal_loss_flag)
    else $error("loss of signal not cleared");
  chg_flag_a: assert property (ce && $changed(ais_defect_flag)
    |=> chg_flags[t1_alarm_pkg::CHG_AIS_BIT])
    else $error("AIS change flag lost");

  ais_cover_c: cover property ($rose(ais_defect_flag));
  yel_cover_c: cover property ($fell(yellow_alarm_flag));
  irq_cover_c: cover property ($rose(irq) && alarm_pending);
  los_cover_c: cover property ($fell(signal_loss_flag) && los_cond);

endmodule // t1_alarm_irq_status

// ==== rtl/t1_alarm_pkg.sv ====
// Register map, field positions and timing constants of the T1 receive alarm block.
// Assumes a 100 MHz aclk and a receive bit strobe at the T1 line rate.
package t1_alarm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BLOCK_IRQ_ENABLE       = 8'h00;
  localparam logic [7:0] OFF_ALARM_ERROR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_ALARM_ERROR_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_FRAME_LOSS_CFG         = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLIP_GROUP_BIT    = 2;
  localparam int ALARM_GROUP_BIT   = 1;
  localparam int FRAMER_GROUP_BIT  = 0;
  localparam int FRAME_LOSS_BIT    = 7;
  localparam int AIS_DEFECT_BIT    = 6;
  localparam int YELLOW_ALARM_BIT  = 5;
  localparam int SIGNAL_LOSS_BIT   = 4;
  localparam int CHG_LCV_BIT       = 3;
  localparam int CHG_FRAME_BIT     = 2;
  localparam int CHG_AIS_BIT       = 1;
  localparam int CHG_YELLOW_BIT    = 0;
  localparam int CHG_FLAGS_W       = 4;
  localparam int TOLERANCE_LSB     = 0;
  localparam int TOLERANCE_W       = 4;
  localparam int WINDOW_LSB        = 8;
  localparam int WINDOW_W          = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]             BLOCK_EN_RESET  = 3'h0;
  localparam logic [3:0]             SRC_EN_RESET    = 4'h0;
  localparam logic [TOLERANCE_W-1:0] TOLERANCE_RESET = 4'h2;
  localparam logic [WINDOW_W-1:0]    WINDOW_RESET    = 8'h05;

  // ----------------------------------------------------------------
  // Timing, counted in received line bits
  // ----------------------------------------------------------------
  localparam int LINE_RATE_HZ        = 1544000;
  localparam int AIS_PERSIST_MS      = 42;
  localparam int YELLOW_PERSIST_MS   = 900;
  localparam int AIS_PERSIST_BITS    = (LINE_RATE_HZ / 1000) * AIS_PERSIST_MS;
  localparam int YELLOW_PERSIST_BITS = (LINE_RATE_HZ / 1000) * YELLOW_PERSIST_MS;
  localparam int LOS_PERSIST_BITS    = 175;
  localparam int ONES_DENSITY_DIV    = 8;
  localparam int LOS_ONES_MIN        = (LOS_PERSIST_BITS + ONES_DENSITY_DIV - 1) / ONES_DENSITY_DIV;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== test/t1_line_source.sv ====
// Remote T1 terminal model: bit strobes, line data, framing checks, raw conditions.
// Assumes one aclk domain; the bench steers the raw conditions.
`timescale 1ns/10ps
module t1_line_source (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ais,
  input  wire logic rai,
  input  wire logic los,
  input  wire logic ferr,
  input  wire logic ones_fill,
  output logic      line_bit_en,
  output logic      line_bit,
  output logic      framing_bit_check,
  output logic      framing_bit_error,
  output logic      ais_cond,
  output logic      rai_cond,
  output logic      los_cond
);
  logic [4:0] div;
  logic [7:0] pat;
  // One bit per four clocks, one framing bit per eight bits
  assign line_bit_en       = (div[1:0] == 2'h3);
  assign framing_bit_check = (div == 5'h1F);
  assign framing_bit_error = framing_bit_check & ferr;
  // Silent line under LOS unless ones_fill keeps the density up
  assign line_bit          = pat[0] & (~los | ones_fill);
  assign ais_cond          = ais;
  assign rai_cond          = rai;
  assign los_cond          = los;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div <= 5'h00;
      pat <= 8'h5A;
    end
    else
    begin
      div <= div + 5'h01;
      if (line_bit_en) pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
    end
  end
endmodule // t1_line_source

// ==== test/tb_top.sv ====
// Self-checking bench for the T1 alarm and interrupt block.
// Assumes the line source model beside it and short persistence counts.
`timescale 1ns/10ps
module tb_top;
  localparam int AIS_N = 8;
  localparam int YEL_N = 16;
  localparam logic [7:0] EN = t1_alarm_pkg::OFF_BLOCK_IRQ_ENABLE;
  localparam logic [7:0] ST = t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_STATUS;
  localparam logic [7:0] SE = t1_alarm_pkg::OFF_ALARM_ERROR_IRQ_ENABLE;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, lcv_event = 1'h0;
  logic slip_irq_pending = 1'h0, framer_irq_pending = 1'h0;
  logic ais = 1'h0, rai = 1'h0, los = 1'h0, ferr = 1'h0, ones_fill = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic line_bit_en, line_bit, framing_bit_check, framing_bit_error;
  logic ais_cond, rai_cond, los_cond;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] lf;
  logic [2:0] en;
  int errors, checks_done;

  t1_alarm_irq_status #(.AIS_PERSIST_BITS(AIS_N), .YELLOW_PERSIST_BITS(YEL_N)) u_dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .line_bit_en, .line_bit, .framing_bit_check,
    .framing_bit_error, .ais_cond, .rai_cond, .los_cond, .lcv_event, .slip_irq_pending,
    .framer_irq_pending, .irq);
  t1_line_source u_src (.aclk, .aresetn, .ais, .rai, .los, .ferr, .ones_fill, .line_bit_en,
    .line_bit, .framing_bit_check, .framing_bit_error, .ais_cond, .rai_cond, .los_cond);

  always #5 aclk = ~aclk;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Counts: %0d checks, %0d errors", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic stop();
    errors++;
    results();
  endtask

  // Master holds each channel until its own ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, bv;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      #1;
      aw = s_axi_awready & s_axi_awvalid;
      w = s_axi_wready & s_axi_wvalid;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (bv) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 50) stop();
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      #1;
      ar = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (rv) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 50) stop();
  endtask

  // Counts line bit strobes, bounded in clocks
  task automatic bits(input int k);
    int n;
    n = 0;
    for (int c = 0; c < 10000 && n < k; c++)
    begin
      @(posedge aclk);
      #1;
      if (line_bit_en) n++;
    end
    @(posedge aclk);
    if (n < k) stop();
  endtask

  task automatic settle(input logic exp);
    repeat (2) @(posedge aclk);
    #1;
    chk(irq, exp);
  endtask

  initial
  begin
    lf = 16'h27F7;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(EN, rd, rsp);
    chk(rd, 32'h0000_0000);
    rdr(t1_alarm_pkg::OFF_FRAME_LOSS_CFG, rd, rsp);
    chk(rd, {16'h0000, t1_alarm_pkg::WINDOW_RESET, 4'h0, t1_alarm_pkg::TOLERANCE_RESET});
    wr(ST, 32'h0000_00F0, rsp);
    rdr(ST, rd, rsp);
    chk(rd, 32'h0000_0000);
    wr(8'h10, 32'h0000_0007, rsp);
    chk(rsp, t1_alarm_pkg::RESP_SLVERR);
    rdr(8'h10, rd, rsp);
    chk(rsp, t1_alarm_pkg::RESP_SLVERR);
    $display("done: registers");
    for (int i = 0; i < 9; i++)
    begin
      lf = lfsr(lf);
      en = (i == 0) ? 3'h2 : (i == 1) ? 3'h4 : (i == 2) ? 3'h1 : lf[2:0];
      wr(EN, {29'h0000_0000, en}, rsp);
      slip_irq_pending <= (i < 3) | lf[5];
      framer_irq_pending <= (i < 3) | lf[6];
      rdr(EN, rd, rsp);
      chk(rd, {29'h0000_0000, en});
      #1;
      chk(irq, en[2] & slip_irq_pending | en[0] & framer_irq_pending);
    end
    slip_irq_pending <= 1'h0;
    framer_irq_pending <= 1'h0;
    wr(EN, 32'h0000_0000, rsp);
    $display("done: group gating");
    wr(SE, 32'h0000_0002, rsp);
    ais <= 1'h1;
    bits(AIS_N - 3);
    rdr(ST, rd, rsp);
    chk(rd[6], 1'h0);
    bits(6);
    settle(1'h0);
    wr(EN, 32'h0000_0002, rsp);
    settle(1'h1);
    rdr(ST, rd, rsp);
    chk(rd[7:0], 8'h42);
    settle(1'h0);
    ais <= 1'h0;
    bits(AIS_N - 3);
    rdr(ST, rd, rsp);
    chk(rd[6], 1'h1);
    bits(6);
    rdr(ST, rd, rsp);
    chk(rd[7:0], 8'h02);
    $display("done: ais");
    rai <= 1'h1;
    bits(YEL_N - 3);
    rdr(ST, rd, rsp);
    chk(rd[5], 1'h0);
    bits(6);
    rdr(ST, rd, rsp);
    chk(rd[5], 1'h1);
    rai <= 1'h0;
    rdr(ST, rd, rsp);
    chk(rd[5], 1'h0);
    $display("done: yellow");
    los <= 1'h1;
    bits(170);
    rdr(ST, rd, rsp);
    chk(rd[4], 1'h0);
    bits(8);
    rdr(ST, rd, rsp);
    chk(rd[4], 1'h1);
    ones_fill <= 1'h1;
    bits(360);
    rdr(ST, rd, rsp);
    chk(rd[4], 1'h0);
    ones_fill <= 1'h0;
    bits(360);
    rdr(ST, rd, rsp);
    chk(rd[4], 1'h1);
    los <= 1'h0;
    rdr(ST, rd, rsp);
    chk(rd[4], 1'h0);
    $display("done: signal loss");
    ferr <= 1'h1;
    bits(40);
    rdr(ST, rd, rsp);
    chk(rd[7], 1'h1);
    ferr <= 1'h0;
    bits(100);
    rdr(ST, rd, rsp);
    chk({rd[7], rd[2]}, 2'h1);
    $display("done: frame loss");
    wr(SE, 32'h0000_0008, rsp);
    ce <= 1'h0;
    lcv_event <= 1'h1;
    @(posedge aclk);
    ce <= 1'h1;
    lcv_event <= 1'h0;
    settle(1'h0);
    @(posedge aclk);
    lcv_event <= 1'h1;
    @(posedge aclk);
    lcv_event <= 1'h0;
    settle(1'h1);
    rdr(ST, rd, rsp);
    chk(rd[3:0], 4'h8);
    $display("done: line code and enable");
    results();
  end
endmodule // tb_top
